// *** design/swl_slot_core.sv ***
// Slot engine and transfer sequencer of a single-wire slave memory device.
// Assumes reset/presence and selection logic outside, which pulses bus_reset and
// select_done, sets overdrive, and serves data_addr from scratchpad or memory.
//
// Behaviour
// - Each slot carries one bit; write slots in, read slots out.
// - Master's falling edge opens a slot and starts the device timer.
// - Device pulls low for a zero bit until its timer releases.
// - Device never pulls low when returning a one.
// - Extra falling-edge filter at standard speed, bypassed in overdrive.
// - Glitches not reaching below the hysteresis level are ignored.
// - Drops inside hold-off are ignored; longer drops open a slot.
// - Identity check byte is the 8-bit check of 56 bits, uninverted.
// - Data check uses the 16-bit polynomial x16+x15+x2+1.
// - The 16-bit check is always sent inverted.
// - Scratch write: clear, shift command, addresses, data; send at offset 111.
// - Scratch read: clear, shift command, addresses, status, data; send at end.
// - Scratch transfers carry eight minus low three offset bits bytes.
// - Memory read streams bytes until the end of memory.
// - After a rejected command, or a finished one other than a successful copy, reads return ones until reset.
// - After a successful copy, reads return AA until reset.
// - Overdrive selects the fast timing set for every slot.
// - Bytes go least significant bit first; AA means copy success.
`timescale 1ns/1ns
`default_nettype none
`include "swl_map.svh"

module swl_slot_core
	import swl_pkg::*;
#(
	parameter logic [11:0] SAMPLE_STD = 12'(`SWL_SAMPLE_STD_CYC),
	parameter logic [11:0] SAMPLE_OD = 12'(`SWL_SAMPLE_OD_CYC),
	parameter logic [11:0] HOLD_STD = 12'(`SWL_HOLD_STD_CYC),
	parameter logic [11:0] HOLD_OD = 12'(`SWL_HOLD_OD_CYC),
	parameter logic [11:0] FILT_STD = 12'(`SWL_FILT_STD_CYC),
	parameter logic [11:0] REH_STD = 12'(`SWL_REH_STD_CYC),
	parameter logic [11:0] REH_OD = 12'(`SWL_REH_OD_CYC),
	parameter logic [15:0] MEM_LAST = `SWL_MEM_LAST
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic line_high,
	input wire logic line_low,
	input wire logic overdrive,
	input wire logic bus_reset,
	input wire logic select_done,
	input wire logic [7:0] data_in,
	input wire logic [7:0] es_byte,
	input wire logic copy_done,
	input wire logic copy_ok,
	input wire logic [63:0] rom_id,
	output logic line_out,
	output logic line_oe,
	output logic [15:0] data_addr,
	output logic scratch_sel,
	output logic wr_strobe,
	output logic [7:0] wr_data,
	output logic copy_req,
	output logic prog_busy,
	output logic [7:0] rom_crc,
	output logic rom_crc_ok
);
	swl_phase_t phase;
	swl_cmd_t cmd;
	logic slot_start;
	logic slot_act;
	logic [11:0] timer;
	logic [11:0] samp_c;
	logic [11:0] hold_c;
	logic [11:0] end_c;
	logic sampled;
	logic [2:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [7:0] next_tx;
	logic load_req;
	logic [15:0] ta;
	logic [3:0] rem;
	logic [1:0] idx;
	logic [7:0] loop_byte;
	logic [15:0] crc;
	logic tx_mode;
	logic engaged;
	logic bit_done;
	logic bit_val;
	logic byte_done;
	logic [7:0] byte_val;
	logic crc_on;

	// ****************************************
	// Edge detection and check generator
	// ****************************************
	swl_edge_det #(
		.FILT_STD(FILT_STD),
		.REH_STD(REH_STD),
		.REH_OD(REH_OD)
	) u_edge (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.overdrive(overdrive),
		.line_high(line_high),
		.line_low(line_low),
		.slot_start(slot_start)
	);

	assign crc_on = (phase == PH_CMD) || (phase == PH_TA1) || (phase == PH_TA2) ||
		(phase == PH_WDATA) || (phase == PH_HDR_TX) || (phase == PH_RDATA);

	swl_crc16 u_crc (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(select_done),
		.shift(bit_done && crc_on),
		.bit_in(bit_val),
		.crc(crc)
	);

	// ****************************************
	// Slot timing
	// ****************************************
	assign samp_c = overdrive ? SAMPLE_OD : SAMPLE_STD;
	assign hold_c = overdrive ? HOLD_OD : HOLD_STD;
	assign end_c = 12'(((hold_c > samp_c) ? hold_c : samp_c) + 12'h001);
	assign tx_mode = (phase == PH_HDR_TX) || (phase == PH_RDATA) ||
		(phase == PH_CRC) || (phase == PH_LOOP);
	// Slots during selection belong to other logic; during programming none are expected
	assign engaged = (phase != PH_IDLE) && (phase != PH_PROG);
	assign bit_done = slot_act && (timer == end_c);
	assign bit_val = tx_mode ? tx_shift[0] : sampled;
	assign byte_done = bit_done && (bit_cnt == 3'h7);
	assign byte_val = {bit_val, rx_shift[7:1]};

	always_ff @(posedge core_clk) begin
		if (!rst_n || bus_reset) begin
			slot_act <= 1'b0;
			timer <= 12'h000;
			line_oe <= 1'b0;
			sampled <= 1'b1;
		end else if (slot_start && !slot_act && engaged) begin
			slot_act <= 1'b1;
			timer <= 12'h000;
			// A one never pulls the line; a zero pulls at once, well inside the read low time
			line_oe <= tx_mode && !tx_shift[0];
		end else if (slot_act) begin
			timer <= timer + 12'h001;
			if (timer == hold_c) begin
				line_oe <= 1'b0;
			end
			if (timer == samp_c) begin
				sampled <= line_high;
			end
			if (timer == end_c) begin
				slot_act <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			line_out <= 1'b0;
		end else begin
			line_out <= 1'b0;
		end
	end

	// ****************************************
	// Bit and byte assembly
	// ****************************************
	always_comb begin
		next_tx = loop_byte;
		case (phase)
			PH_HDR_TX: begin
				next_tx = (idx == 2'h0) ? ta[7:0] : ((idx == 2'h1) ? ta[15:8] : es_byte);
			end
			PH_RDATA: begin
				next_tx = data_in;
			end
			PH_CRC: begin
				next_tx = (idx == 2'h0) ? ~crc[7:0] : ~crc[15:8];
			end
			PH_LOOP: begin
				next_tx = loop_byte;
			end
			default: begin
				next_tx = `SWL_FILL_BYTE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || bus_reset || select_done) begin
			bit_cnt <= 3'h0;
			rx_shift <= 8'h00;
			tx_shift <= `SWL_FILL_BYTE;
		end else if (bit_done) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_shift <= byte_val;
			tx_shift <= {1'b1, tx_shift[7:1]};
		end else if (load_req) begin
			tx_shift <= next_tx;
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n || bus_reset) begin
			phase <= PH_IDLE;
			cmd <= CK_WRITE;
			load_req <= 1'b0;
			idx <= 2'h0;
			rem <= 4'h0;
			loop_byte <= `SWL_FILL_BYTE;
			data_addr <= 16'h0000;
			scratch_sel <= 1'b0;
			wr_strobe <= 1'b0;
			wr_data <= 8'h00;
			copy_req <= 1'b0;
			if (!rst_n) begin
				ta <= 16'h0000;
			end
		end else begin
			load_req <= 1'b0;
			wr_strobe <= 1'b0;
			copy_req <= 1'b0;
			// Step only after the strobe, so the write lands on the byte's own address
			if (wr_strobe) begin
				data_addr <= data_addr + 16'h0001;
			end
			if (select_done) begin
				phase <= PH_CMD;
			end else if (phase == PH_PROG) begin
				if (copy_done) begin
					phase <= PH_LOOP;
					loop_byte <= copy_ok ? `SWL_DONE_BYTE : `SWL_FILL_BYTE;
					load_req <= 1'b1;
				end
			end else if (byte_done) begin
				case (phase)
					PH_CMD: begin
						case (byte_val)
							`SWL_CMD_WRITE_SCR: begin
								cmd <= CK_WRITE;
								phase <= PH_TA1;
							end
							`SWL_CMD_READ_SCR: begin
								cmd <= CK_READ;
								phase <= PH_HDR_TX;
								idx <= 2'h0;
								load_req <= 1'b1;
							end
							`SWL_CMD_COPY_SCR: begin
								cmd <= CK_COPY;
								phase <= PH_TA1;
							end
							`SWL_CMD_READ_MEM: begin
								cmd <= CK_MEM;
								phase <= PH_TA1;
							end
							default: begin
								phase <= PH_LOOP;
								loop_byte <= `SWL_FILL_BYTE;
								load_req <= 1'b1;
							end
						endcase
					end
					PH_TA1: begin
						ta[7:0] <= byte_val;
						phase <= PH_TA2;
					end
					PH_TA2: begin
						ta[15:8] <= byte_val;
						data_addr <= {byte_val, ta[7:0]};
						scratch_sel <= (cmd != CK_MEM);
						rem <= `SWL_SCR_SIZE - {1'b0, ta[2:0]};
						if (cmd == CK_WRITE) begin
							phase <= PH_WDATA;
						end else if (cmd == CK_COPY) begin
							phase <= PH_ES_RX;
						end else if ({byte_val, ta[7:0]} > MEM_LAST) begin
							phase <= PH_LOOP;
							loop_byte <= `SWL_FILL_BYTE;
							load_req <= 1'b1;
						end else begin
							phase <= PH_RDATA;
							load_req <= 1'b1;
						end
					end
					PH_WDATA: begin
						wr_strobe <= 1'b1;
						wr_data <= byte_val;
						rem <= rem - 4'h1;
						if (rem == 4'h1) begin
							// Last byte lands on offset 111, so the check follows
							phase <= PH_CRC;
							idx <= 2'h0;
							load_req <= 1'b1;
						end
					end
					PH_ES_RX: begin
						copy_req <= 1'b1;
						phase <= PH_PROG;
					end
					PH_HDR_TX: begin
						load_req <= 1'b1;
						if (idx == 2'h2) begin
							phase <= PH_RDATA;
							data_addr <= ta;
							scratch_sel <= 1'b1;
							rem <= `SWL_SCR_SIZE - {1'b0, ta[2:0]};
						end else begin
							idx <= idx + 2'h1;
						end
					end
					PH_RDATA: begin
						load_req <= 1'b1;
						data_addr <= data_addr + 16'h0001;
						rem <= rem - 4'h1;
						if (scratch_sel && (rem == 4'h1)) begin
							phase <= PH_CRC;
							idx <= 2'h0;
						end else if (!scratch_sel && (data_addr == MEM_LAST)) begin
							phase <= PH_LOOP;
							loop_byte <= `SWL_FILL_BYTE;
						end
					end
					PH_CRC: begin
						load_req <= 1'b1;
						if (idx == 2'h1) begin
							phase <= PH_LOOP;
							loop_byte <= `SWL_FILL_BYTE;
						end else begin
							idx <= 2'h1;
						end
					end
					PH_LOOP: begin
						load_req <= 1'b1;
					end
					default: begin
						phase <= PH_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Status and identity check
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prog_busy <= 1'b0;
		end else begin
			prog_busy <= (phase == PH_PROG);
		end
	end

	// Long combinational chain; registered so it never limits the slot logic
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rom_crc <= 8'h00;
			rom_crc_ok <= 1'b0;
		end else begin
			rom_crc <= swl_crc8_56(rom_id[55:0]);
			rom_crc_ok <= (rom_crc == rom_id[63:56]);
		end
	end

endmodule

`default_nettype wire

// *** design/swl_map.svh ***
// Constants of the single-wire slot and check engine: timing, command codes, patterns.
// Assumes a 100 MHz core clock; counts are derived from the figures below.
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SWL_CLK_MHZ 100
`define SWL_CYC_MIN(ns) ((((ns) * `SWL_CLK_MHZ) + 999) / 1000)
`define SWL_CYC_MAX(ns) (((ns) * `SWL_CLK_MHZ) / 1000)
`define SWL_SAMPLE_STD_NS 25000
`define SWL_SAMPLE_OD_NS 2000
`define SWL_HOLD_STD_NS 30000
`define SWL_HOLD_OD_NS 3000
`define SWL_REH_STD_NS 5000
`define SWL_REH_OD_NS 2000
`define SWL_FILT_STD_NS 1000
`define SWL_SAMPLE_STD_CYC `SWL_CYC_MIN(`SWL_SAMPLE_STD_NS)
`define SWL_SAMPLE_OD_CYC `SWL_CYC_MIN(`SWL_SAMPLE_OD_NS)
`define SWL_HOLD_STD_CYC `SWL_CYC_MIN(`SWL_HOLD_STD_NS)
`define SWL_HOLD_OD_CYC `SWL_CYC_MIN(`SWL_HOLD_OD_NS)
`define SWL_REH_STD_CYC `SWL_CYC_MIN(`SWL_REH_STD_NS)
`define SWL_REH_OD_CYC `SWL_CYC_MIN(`SWL_REH_OD_NS)
`define SWL_FILT_STD_CYC `SWL_CYC_MIN(`SWL_FILT_STD_NS)

// ****************************************
// Commands, patterns, checks
// ****************************************
`define SWL_CMD_WRITE_SCR 8'h0f
`define SWL_CMD_READ_SCR 8'haa
`define SWL_CMD_COPY_SCR 8'h55
`define SWL_CMD_READ_MEM 8'hf0
`define SWL_FILL_BYTE 8'hff
`define SWL_DONE_BYTE 8'haa
`define SWL_CRC16_POLY 16'ha001
`define SWL_CRC16_INIT 16'h0000
`define SWL_CRC8_POLY 8'h8c
`define SWL_MEM_LAST 16'h008f
`define SWL_SCR_SIZE 4'h8

`endif

// *** design/swl_pkg.sv ***
// Types and shared arithmetic of the single-wire slot and check engine.
// Assumes swl_map.svh is on the include path.
`include "swl_map.svh"

package swl_pkg;

	// ****************************************
	// Transfer phases
	// ****************************************
	typedef enum logic [10:0] {
		PH_IDLE = 11'h001,
		PH_CMD = 11'h002,
		PH_TA1 = 11'h004,
		PH_TA2 = 11'h008,
		PH_ES_RX = 11'h010,
		PH_WDATA = 11'h020,
		PH_HDR_TX = 11'h040,
		PH_RDATA = 11'h080,
		PH_CRC = 11'h100,
		PH_PROG = 11'h200,
		PH_LOOP = 11'h400
	} swl_phase_t;

	typedef enum logic [3:0] {
		CK_WRITE = 4'h1,
		CK_READ = 4'h2,
		CK_COPY = 4'h4,
		CK_MEM = 4'h8
	} swl_cmd_t;

	// 8-bit check over the first 56 identity bits, least significant bit first
	function automatic logic [7:0] swl_crc8_56(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			if (c[0] ^ d[i]) begin
				c = (c >> 1) ^ `SWL_CRC8_POLY;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction

endpackage

// *** design/swl_edge_det.sv ***
// Slot-opening edge detector with low-pass filter and rising-edge hold-off.
// Assumes line_high/line_low come from comparators, synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
`include "swl_map.svh"

module swl_edge_det #(
	parameter logic [11:0] FILT_STD = 12'(`SWL_FILT_STD_CYC),
	parameter logic [11:0] REH_STD = 12'(`SWL_REH_STD_CYC),
	parameter logic [11:0] REH_OD = 12'(`SWL_REH_OD_CYC)
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic overdrive,
	input wire logic line_high,
	input wire logic line_low,
	output logic slot_start
);
	logic armed;
	logic was_high;
	logic [11:0] reh_cnt;
	logic [11:0] low_cnt;
	logic [11:0] thr_m1;
	logic fire;

	// Overdrive skips the extra filtering: one low cycle opens a slot
	assign thr_m1 = overdrive ? 12'h000 : 12'(FILT_STD - 12'h001);
	// Only a drop below the hysteresis level counts; a dip through the upper level alone is ignored
	assign fire = armed && (reh_cnt == 12'h000) && line_low && (low_cnt >= thr_m1);

	// ****************************************
	// Hold-off after the line crosses high
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			was_high <= 1'b1;
			reh_cnt <= 12'h000;
		end else begin
			was_high <= line_high;
			if (line_high && !was_high) begin
				reh_cnt <= overdrive ? REH_OD : REH_STD;
			end else if (reh_cnt != 12'h000) begin
				reh_cnt <= reh_cnt - 12'h001;
			end
		end
	end

	// ****************************************
	// Low filter and arming
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			low_cnt <= 12'h000;
		end else if (!line_low) begin
			low_cnt <= 12'h000;
		end else if (low_cnt != 12'hfff) begin
			// A drop still low when the hold-off ends is taken as a new slot
			low_cnt <= low_cnt + 12'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			armed <= 1'b1;
			slot_start <= 1'b0;
		end else begin
			slot_start <= fire;
			if (fire) begin
				armed <= 1'b0;
			end else if (line_high && !was_high) begin
				armed <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// *** design/swl_crc16.sv ***
// Serial 16-bit check generator, one bit per shift, least significant bit first.
// Assumes the caller clears it before the first bit of a command.
`timescale 1ns/1ns
`default_nettype none
`include "swl_map.svh"

module swl_crc16 (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic shift,
	input wire logic bit_in,
	output logic [15:0] crc
);
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			crc <= `SWL_CRC16_INIT;
		end else if (clear) begin
			crc <= `SWL_CRC16_INIT;
		end else if (shift) begin
			// Reflected form of x16+x15+x2+1
			if (crc[0] ^ bit_in) begin
				crc <= (crc >> 1) ^ `SWL_CRC16_POLY;
			end else begin
				crc <= crc >> 1;
			end
		end
	end

endmodule

`default_nettype wire

// *** bench/swl_slot_core_checker.sv ***
// Port-level checks of the slot engine: pulldown timing, strobes, busy, identity check.
// Assumes binding into swl_slot_core, single clock domain.
`timescale 1ns/1ns
`default_nettype none

module swl_slot_core_checker #(
	parameter logic [11:0] HOLD_STD = 12'h01e,
	parameter logic [11:0] HOLD_OD = 12'h00c
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic overdrive,
	input wire logic bus_reset,
	input wire logic line_low,
	input wire logic copy_done,
	input wire logic [63:0] rom_id,
	input wire logic line_out,
	input wire logic line_oe,
	input wire logic wr_strobe,
	input wire logic copy_req,
	input wire logic prog_busy,
	input wire logic [7:0] rom_crc,
	input wire logic rom_crc_ok
);
	// ****
	// Pulldown length counter
	// ****
	logic [12:0] n_oe;
	logic [12:0] lim;
	assign lim = overdrive ? {1'h0, HOLD_OD} : {1'h0, HOLD_STD};
	always_ff @(posedge core_clk) begin
		if (!rst_n || !line_oe) begin
			n_oe <= 13'h0;
		end else begin
			n_oe <= n_oe + 13'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	drain_only_a: assert property (line_out == 1'h0) else $error("line_out driven high");
	oe_in_slot_a: assert property ($rose(line_oe) |-> $past(line_low))
		else $error("pulldown without master edge");
	oe_length_a: assert property ($fell(line_oe) |-> (n_oe >= lim && n_oe <= lim + 13'h2))
		else $error("pulldown length wrong");
	oe_bound_a: assert property (line_oe |-> n_oe <= lim + 13'h2)
		else $error("pulldown too long");
	quiet_prog_a: assert property (prog_busy |-> !line_oe) else $error("drive while busy");
	strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe) else $error("write strobe long");
	copy_busy_a: assert property (copy_req |=> !copy_req ##[0:1] prog_busy)
		else $error("copy request without busy");
	busy_end_a: assert property ($fell(prog_busy) |->
		($past(copy_done) || $past(copy_done, 2) || $past(bus_reset) || $past(bus_reset, 2)))
		else $error("busy ended without completion");
	id_check_a: assert property ($changed(rom_id) |-> ##2
		(rom_crc_ok == (rom_crc == rom_id[63:56]))) else $error("identity check flag wrong");
endmodule

`default_nettype wire

// *** bench/swl_master_model.sv ***
// Bus master model on the shared open-drain line, behavioural slot timing.
// Assumes the bench resolves the wire from m_low and the device pulldown.
`timescale 1ns/1ns
`default_nettype none

module swl_master_model (
	input wire logic core_clk,
	input wire logic line,
	input wire logic od,
	output logic m_low,
	output logic gl_hi
);
	initial begin
		m_low = 1'h0;
		gl_hi = 1'h0;
	end
	// ****
	// Slots and bytes
	// ****
	// Noise g: short deep drop inside hold-off, then a shallow dip after sampling
	task automatic slot(input logic b, input logic g, output logic r);
		int lo;
		int smp;
		int tot;
		lo = b ? (od ? 3 : 6) : (od ? 210 : 26);
		smp = od ? 250 : 15;
		tot = od ? 320 : 45;
		r = 1'h0;
		@(negedge core_clk) m_low = 1'h1;
		for (int i = 0; i < tot; i++) begin
			@(negedge core_clk);
			if (i == lo) m_low = 1'h0;
			if (g && i == lo + 1) m_low = 1'h1;
			if (g && i == lo + 4) m_low = 1'h0;
			if (g && i == 30) gl_hi = 1'h1;
			if (g && i == 33) gl_hi = 1'h0;
			if (i == smp) r = line;
		end
	endtask
	// Drop shorter than the standard-speed filter; must not open a slot
	task automatic spike(input int n);
		@(negedge core_clk) m_low = 1'h1;
		repeat (n) @(negedge core_clk);
		m_low = 1'h0;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic wbyte(input logic [7:0] d, input logic g);
		logic r;
		for (int i = 0; i < 8; i++) slot(d[i], g, r);
	endtask
	task automatic rbyte(output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			slot(1'h1, 1'h0, r);
			d[i] = r;
		end
	endtask
endmodule

`default_nettype wire

// *** bench/test_swl_slot_core.sv ***
// Self-checking bench of the slot engine: commands, checks, loops, noise, overdrive.
// Assumes the master model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none

module test_swl_slot_core;
	localparam logic [55:0] ID = 56'h5a3c0f96e1d2b4;
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic overdrive = 1'h0;
	logic bus_reset = 1'h0;
	logic select_done = 1'h0;
	logic [7:0] data_in = 8'h0;
	logic [7:0] es_byte = 8'h07;
	logic copy_done = 1'h0;
	logic copy_ok = 1'h0;
	logic [63:0] rom_id = 64'h0;
	logic line_out, line_oe, scratch_sel, wr_strobe, copy_req, prog_busy, rom_crc_ok;
	logic [15:0] data_addr;
	logic [7:0] wr_data, rom_crc, r;
	logic m_low, gl_hi;
	wire logic line, line_high, line_low;
	int n_fail = 0;
	int compares = 0;
	logic [15:0] n_req = 16'h0;
	logic [15:0] crc;
	logic [23:0] wq[$];
	logic [7:0] wd[3] = '{8'hc3, 8'h3c, 8'h81};
	assign line = !(m_low || line_oe);
	assign line_high = line && !gl_hi;
	assign line_low = !line;
	always #5 core_clk = ~core_clk;
	// Memory stand-in, answers half a cycle after the address moves
	always @(negedge core_clk) data_in <= data_addr[7:0] ^ 8'h5a;
	always @(posedge core_clk) begin
		if (wr_strobe) wq.push_back({data_addr, wr_data});
		if (copy_req) n_req <= n_req + 16'h1;
	end
	// Standard counts shrunk to keep slots short; overdrive keeps its sample and hold defaults
	swl_slot_core #(.SAMPLE_STD(12'h014), .HOLD_STD(12'h01e),
		.FILT_STD(12'h003), .REH_STD(12'h005), .REH_OD(12'h003)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .line_high(line_high), .line_low(line_low),
		.overdrive(overdrive), .bus_reset(bus_reset), .select_done(select_done),
		.data_in(data_in), .es_byte(es_byte), .copy_done(copy_done), .copy_ok(copy_ok),
		.rom_id(rom_id), .line_out(line_out), .line_oe(line_oe), .data_addr(data_addr),
		.scratch_sel(scratch_sel), .wr_strobe(wr_strobe), .wr_data(wr_data),
		.copy_req(copy_req), .prog_busy(prog_busy), .rom_crc(rom_crc), .rom_crc_ok(rom_crc_ok));
	swl_master_model mst (.core_clk(core_clk), .line(line), .od(overdrive), .m_low(m_low),
		.gl_hi(gl_hi));
	// ****
	// Helpers
	// ****
	task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] cb(input logic [15:0] c, input logic [7:0] d,
		input logic [15:0] p);
		for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
		return c;
	endfunction
	task tx(input logic [7:0] d, input logic g);
		mst.wbyte(d, g);
		crc = cb(crc, d, 16'ha001);
	endtask
	task rx(input string nm, input logic [7:0] e);
		mst.rbyte(r);
		cmp(nm, {8'h0, e}, {8'h0, r});
		crc = cb(crc, e, 16'ha001);
	endtask
	task begin_cmd(input logic [7:0] c);
		@(negedge core_clk) bus_reset = 1'h1;
		@(negedge core_clk) bus_reset = 1'h0;
		select_done = 1'h1;
		@(negedge core_clk) select_done = 1'h0;
		crc = 16'h0;
		tx(c, 1'h0);
	endtask
	task results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task t_rom;
		logic [15:0] c;
		c = 16'h0;
		for (int i = 0; i < 7; i++) c = cb(c, ID[8*i +: 8], 16'h008c);
		@(negedge core_clk) rom_id = {c[7:0], ID};
		repeat (3) @(negedge core_clk);
		cmp("id check", c, {8'h0, rom_crc});
		cmp("id ok", 16'h1, {15'h0, rom_crc_ok});
		rom_id[63:56] = ~c[7:0];
		repeat (3) @(negedge core_clk);
		cmp("id bad", 16'h0, {15'h0, rom_crc_ok});
	endtask
	task t_write;
		logic [15:0] e;
		wq.delete();
		begin_cmd(8'h0f);
		tx(8'h05, 1'h0);
		tx(8'h00, 1'h0);
		for (int k = 0; k < 3; k++) tx(wd[k], 1'h1);
		e = ~crc;
		rx("wcrc low", e[7:0]);
		rx("wcrc high", e[15:8]);
		rx("wfill", 8'hff);
		cmp("writes", 16'h3, 16'(wq.size()));
		for (int k = 0; k < 3; k++) begin
			cmp("wr addr", 16'h0005 + 16'(k), wq[k][23:8]);
			cmp("wr data", {8'h0, wd[k]}, {8'h0, wq[k][7:0]});
		end
	endtask
	task t_read;
		logic [15:0] e;
		begin_cmd(8'haa);
		rx("ta low", 8'h05);
		rx("ta high", 8'h00);
		rx("status", es_byte);
		for (int k = 0; k < 3; k++) rx("scratch", (8'h05 + 8'(k)) ^ 8'h5a);
		cmp("sel", 16'h1, {15'h0, scratch_sel});
		e = ~crc;
		rx("rcrc low", e[7:0]);
		rx("rcrc high", e[15:8]);
		rx("rfill", 8'hff);
	endtask
	task t_copy(input logic ok);
		logic [15:0] n0;
		n0 = n_req;
		begin_cmd(8'h55);
		tx(8'h05, 1'h0);
		tx(8'h00, 1'h0);
		tx(8'h07, 1'h0);
		repeat (3) @(negedge core_clk);
		cmp("copy req", n0 + 16'h1, n_req);
		cmp("busy", 16'h1, {15'h0, prog_busy});
		repeat (20) @(negedge core_clk);
		copy_ok = ok;
		copy_done = 1'h1;
		@(negedge core_clk) copy_done = 1'h0;
		repeat (3) @(negedge core_clk);
		cmp("idle", 16'h0, {15'h0, prog_busy});
		rx("copy status", ok ? 8'haa : 8'hff);
		mst.spike(2);
		rx("copy loop", ok ? 8'haa : 8'hff);
	endtask
	task t_mem;
		@(negedge core_clk) overdrive = 1'h1;
		begin_cmd(8'hf0);
		tx(8'h8d, 1'h0);
		tx(8'h00, 1'h0);
		for (int k = 0; k < 3; k++) rx("mem", (8'h8d + 8'(k)) ^ 8'h5a);
		rx("eom fill", 8'hff);
		cmp("mem sel", 16'h0, {15'h0, scratch_sel});
		@(negedge core_clk) overdrive = 1'h0;
		begin_cmd(8'hf0);
		tx(8'h90, 1'h0);
		tx(8'h00, 1'h0);
		rx("bad addr", 8'hff);
		begin_cmd(8'h33);
		rx("bad cmd", 8'hff);
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		rst_n = 1'h1;
		t_rom;
		t_write;
		t_read;
		t_copy(1'h1);
		t_copy(1'h0);
		t_mem;
		results;
	end
	// Run needs about 32000 cycles; the limit leaves ample margin
	initial begin
		#600000;
		n_fail++;
		results;
	end
endmodule

bind swl_slot_core swl_slot_core_checker #(.HOLD_STD(HOLD_STD), .HOLD_OD(HOLD_OD)) chk (
	.core_clk(core_clk), .rst_n(rst_n), .overdrive(overdrive), .bus_reset(bus_reset),
	.line_low(line_low), .copy_done(copy_done), .rom_id(rom_id), .line_out(line_out),
	.line_oe(line_oe), .wr_strobe(wr_strobe), .copy_req(copy_req), .prog_busy(prog_busy),
	.rom_crc(rom_crc), .rom_crc_ok(rom_crc_ok));

`default_nettype wire
